/* File: hdl/serial_host.sv */
// Purpose: host end driving the serial register access port
// Assumes: software on avalon-mm, word addressed, waitrequest answer
// Notes: host makes the serial clock by dividing clk
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
module serial_host
  import access_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  serial_link_if.host link
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  host_state_e state_reg;
  logic [7:0] cmd_reg;
  logic [1:0] len_reg;
  logic [DATA_BITS-1:0] txd_reg;
  logic [DATA_BITS-1:0] rx_sh_reg;
  logic [30:0] tx_sh_reg;
  logic [5:0] bit_idx_reg;
  logic [7:0] tmr_reg;
  logic done_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic din_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [1:0] miso_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_s <= 2'h3;
    end else begin
      miso_s <= {miso_s[0], link.miso};
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire access = (avs_read | avs_write) & ~wait_reg;
  wire ctrl_wr = avs_write & ~wait_reg & (avs_address == CTRL_IDX);
  wire txd_wr = avs_write & ~wait_reg & (avs_address == TXD_IDX);
  wire idle = (state_reg == H_IDLE);
  wire start = ctrl_wr & avs_writedata[CTRL_START_POS] & idle;
  wire [1:0] wlen = avs_writedata[CTRL_LEN_POS+1:CTRL_LEN_POS];
  wire [1:0] new_len = (wlen == 2'h0) ? 2'h1 : wlen;
  wire [7:0] new_cmd = avs_writedata[7:0];
  wire is_write = cmd_reg[DIR_POS];
  // index of the final bit: eight command bits plus len data bytes, counted from 0
  wire [5:0] last_idx = {1'b0, len_reg, 3'h7};
  wire [DATA_BITS-1:0] tx_left = (new_len == 2'h1) ? {txd_reg[7:0], 16'h0000} :
                                 (new_len == 2'h2) ? {txd_reg[15:0], 8'h00} : txd_reg;
  wire [DATA_BITS-1:0] rx_mask = (len_reg == 2'h1) ? 24'h00_00FF :
                                 (len_reg == 2'h2) ? 24'h00_FFFF : 24'hFF_FFFF;
  wire [31:0] rd_mux = (avs_address == CTRL_IDX) ? {22'h0, len_reg, cmd_reg} :
                       (avs_address == TXD_IDX) ? {8'h00, txd_reg} :
                       (avs_address == RXD_IDX) ? {8'h00, rx_sh_reg & rx_mask} :
                       {30'h0, done_reg, ~idle};
  wire tmr_zero = (tmr_reg == 8'h00);
  wire at_last = (bit_idx_reg == last_idx);
  // a write data byte ends: hold off before the next one
  wire need_gap = is_write & (bit_idx_reg[2:0] == 3'h7) & (bit_idx_reg >= 6'h08);
  localparam logic [7:0] HALF_LOAD = 8'(HALF_CYCLES - 1);
  localparam logic [7:0] GAP_LOAD = 8'(GAP_CYCLES - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      cmd_reg <= 8'h00;
      len_reg <= LEN_RESET;
      txd_reg <= '0;
    end else begin
      wait_reg <= ~access & (avs_read | avs_write) ? 1'b0 : 1'b1;
      if ((avs_read | avs_write) && wait_reg) begin
        rdata_reg <= avs_read ? rd_mux : 32'h0000_0000;
      end
      if (ctrl_wr && idle) begin
        cmd_reg <= new_cmd;
        len_reg <= new_len;
      end
      if (txd_wr) begin
        txd_reg <= avs_writedata[DATA_BITS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // serial sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= H_IDLE;
      sclk_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      din_reg <= 1'b0;
      tx_sh_reg <= '0;
      rx_sh_reg <= '0;
      bit_idx_reg <= 6'h00;
      tmr_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      if (!tmr_zero) begin
        tmr_reg <= tmr_reg - 8'h01;
      end
      unique case (state_reg)
        H_IDLE: begin
          if (start) begin
            cs_n_reg <= 1'b0;
            din_reg <= new_cmd[7];
            tx_sh_reg <= {new_cmd[6:0], tx_left};
            rx_sh_reg <= '0;
            bit_idx_reg <= 6'h00;
            tmr_reg <= HALF_LOAD;
            done_reg <= 1'b0;
            state_reg <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tmr_zero) begin
            sclk_reg <= 1'b0;
            rx_sh_reg <= {rx_sh_reg[DATA_BITS-2:0], miso_s[1]};
            tmr_reg <= HALF_LOAD;
            state_reg <= H_LOW;
          end
        end
        H_LOW: begin
          if (tmr_zero) begin
            sclk_reg <= 1'b1;
            if (at_last) begin
              // every transfer runs to its last bit
              tmr_reg <= is_write ? GAP_LOAD : HALF_LOAD;
              state_reg <= H_END;
            end else if (need_gap) begin
              tmr_reg <= GAP_LOAD;
              state_reg <= H_GAP;
            end else begin
              din_reg <= tx_sh_reg[30];
              tx_sh_reg <= {tx_sh_reg[29:0], 1'b0};
              bit_idx_reg <= bit_idx_reg + 6'h01;
              tmr_reg <= HALF_LOAD;
              state_reg <= H_HIGH;
            end
          end
        end
        H_GAP: begin
          if (tmr_zero) begin
            din_reg <= tx_sh_reg[30];
            tx_sh_reg <= {tx_sh_reg[29:0], 1'b0};
            bit_idx_reg <= bit_idx_reg + 6'h01;
            tmr_reg <= HALF_LOAD;
            state_reg <= H_HIGH;
          end
        end
        H_END: begin
          // select held low until the last bit
          cs_n_reg <= 1'b1;
          if (tmr_zero) begin
            done_reg <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.din = din_reg;

endmodule : serial_host

/* File: hdl/access_pkg.sv */
// Purpose: shared constants and types for the serial register access port
// Assumes: system clock of 40 MHz on both ends
// Notes: times are in ns; cycle counts derive from them
package access_pkg;

  // ----------------------------------------------------------------
  // command byte layout
  // ----------------------------------------------------------------
  localparam int CMD_BITS = 8;
  localparam int DIR_POS = 7;
  localparam int ADDR_BITS = 5;
  localparam int DATA_BITS = 24;
  localparam logic [1:0] MAX_BYTES = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int WRITE_GAP_NS = 4000;
  localparam int GAP_CYCLES = (WRITE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_NS = 200;
  localparam int HALF_CYCLES = SCLK_HALF_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // host register map (word index on the avalon bus)
  // ----------------------------------------------------------------
  localparam logic [1:0] CTRL_IDX = 2'h0;
  localparam logic [1:0] TXD_IDX = 2'h1;
  localparam logic [1:0] RXD_IDX = 2'h2;
  localparam logic [1:0] STAT_IDX = 2'h3;
  localparam int CTRL_LEN_POS = 8;
  localparam int CTRL_START_POS = 31;
  localparam logic [1:0] LEN_RESET = 2'h1;

  typedef enum logic [1:0] {
    D_CMD = 2'b00,
    D_LOAD = 2'b01,
    D_READ = 2'b11,
    D_WRITE = 2'b10
  } dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_HIGH = 3'b001,
    H_LOW = 3'b011,
    H_GAP = 3'b010,
    H_END = 3'b110
  } host_state_e;

endpackage : access_pkg

/* File: hdl/serial_link_if.sv */
// Purpose: four-wire serial link between host and register port
// Assumes: data output is three-state on the device side
// Notes: an undriven data line reads as 1 (pull-up)
`timescale 1ns/10ps
interface serial_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe;
  logic miso;

  assign miso = dout_oe ? dout : 1'b1;

  modport device (input sclk, input cs_n, input din, output dout, output dout_oe);
  modport host (output sclk, output cs_n, output din, input miso);
endinterface : serial_link_if

/* File: hdl/register_port.sv */
// Purpose: device end of the serial register access port
// Assumes: link pins are asynchronous; rd_data/reg_len answer reg_addr in the same cycle
// Notes: each received write byte is handed out as one wr_strobe pulse
`timescale 1ns/10ps
module register_port
  import access_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  serial_link_if.device link,
  output logic [ADDR_BITS-1:0] reg_addr,
  input wire logic [1:0] reg_len,
  input wire logic [DATA_BITS-1:0] rd_data,
  output logic wr_strobe,
  output logic [7:0] wr_data,
  output logic [1:0] wr_byte_idx
);

  // ----------------------------------------------------------------
  // synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] sclk_s;
  logic [2:0] cs_s;
  logic [1:0] din_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s <= 3'h7;
      cs_s <= 3'h7;
      din_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      cs_s <= {cs_s[1:0], link.cs_n};
      din_s <= {din_s[0], link.din};
    end
  end

  wire sclk_fall = sclk_s[2] & ~sclk_s[1];
  wire sclk_rise = ~sclk_s[2] & sclk_s[1];
  wire cs_fall = cs_s[2] & ~cs_s[1];
  wire cs_rise = ~cs_s[2] & cs_s[1];
  wire cs_low = ~cs_s[1];
  wire din_bit = din_s[1];

  // ----------------------------------------------------------------
  // state and datapath registers
  // ----------------------------------------------------------------
  dev_state_e state_reg;
  logic [6:0] cmd_sh_reg;
  logic dir_write_reg;
  logic [ADDR_BITS-1:0] addr_reg;
  logic [2:0] bit_cnt_reg;
  logic [1:0] bytes_left_reg;
  logic [DATA_BITS-1:0] rd_sh_reg;
  logic [6:0] wr_sh_reg;
  logic dout_reg;
  logic dout_oe_reg;
  logic wr_strobe_reg;
  logic [7:0] wr_data_reg;
  logic [1:0] wr_idx_reg;

  // zero length is taken as one byte
  wire [1:0] len_eff = (reg_len == 2'h0) ? 2'h1 : reg_len;
  wire [DATA_BITS-1:0] load_val = (len_eff == 2'h1) ? {rd_data[7:0], 16'h0000} :
                                  (len_eff == 2'h2) ? {rd_data[15:0], 8'h00} : rd_data;
  wire byte_done = (bit_cnt_reg == 3'h7);
  wire [7:0] cmd_byte = {cmd_sh_reg, din_bit};
  wire [7:0] wr_byte = {wr_sh_reg, din_bit};

  // ----------------------------------------------------------------
  // control sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= D_CMD;
      cmd_sh_reg <= 7'h00;
      dir_write_reg <= 1'b0;
      addr_reg <= '0;
      bit_cnt_reg <= 3'h0;
      bytes_left_reg <= 2'h0;
      rd_sh_reg <= '0;
      wr_sh_reg <= 7'h00;
      dout_reg <= 1'b0;
      dout_oe_reg <= 1'b0;
      wr_strobe_reg <= 1'b0;
      wr_data_reg <= 8'h00;
      wr_idx_reg <= 2'h0;
    end else begin
      wr_strobe_reg <= 1'b0;
      if (cs_fall || cs_rise) begin
        // select fall restarts in command mode
        // select rise aborts and floats output
        state_reg <= D_CMD;
        bit_cnt_reg <= 3'h0;
        dout_oe_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          D_CMD: begin
            if (sclk_fall && cs_low) begin
              cmd_sh_reg <= cmd_byte[6:0];
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (byte_done) begin
                dir_write_reg <= cmd_byte[DIR_POS];
                addr_reg <= cmd_byte[ADDR_BITS-1:0];
                state_reg <= D_LOAD;
              end
            end
          end
          D_LOAD: begin
            rd_sh_reg <= load_val;
            bytes_left_reg <= len_eff - 2'h1;
            bit_cnt_reg <= 3'h0;
            state_reg <= dir_write_reg ? D_WRITE : D_READ;
          end
          D_WRITE: begin
            if (sclk_fall) begin
              wr_sh_reg <= wr_byte[6:0];
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (byte_done) begin
                wr_strobe_reg <= 1'b1;
                wr_data_reg <= wr_byte;
                wr_idx_reg <= bytes_left_reg;
                if (bytes_left_reg == 2'h0) begin
                  state_reg <= D_CMD;
                end else begin
                  bytes_left_reg <= bytes_left_reg - 2'h1;
                end
              end
            end
          end
          D_READ: begin
            if (sclk_rise) begin
              dout_reg <= rd_sh_reg[DATA_BITS-1];
              rd_sh_reg <= {rd_sh_reg[DATA_BITS-2:0], 1'b0};
              dout_oe_reg <= 1'b1;
            end
            if (sclk_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (byte_done) begin
                if (bytes_left_reg == 2'h0) begin
                  state_reg <= D_CMD;
                  dout_oe_reg <= 1'b0;
                end else begin
                  bytes_left_reg <= bytes_left_reg - 2'h1;
                end
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.dout = dout_reg;
  assign link.dout_oe = dout_oe_reg;
  assign reg_addr = addr_reg;
  assign wr_strobe = wr_strobe_reg;
  assign wr_data = wr_data_reg;
  assign wr_byte_idx = wr_idx_reg;

endmodule : register_port

/* File: dv/serial_register_access_port_sva.sv */
// Purpose: link checks between the serial host and the register port
// Assumes: sclk half period of several clk cycles, made by the host
// Notes: the device answers the link a few clk late through its synchronisers
`timescale 1ns/10ps
module serial_register_access_port_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  logic sclk_reg;
  logic dir_reg;
  logic [3:0] since_rise_reg;
  logic [3:0] since_fall_reg;
  logic [5:0] nfall_reg;
  logic sclk_rise;
  logic sclk_fall;

  // ----------------------------------------------------------------
  // link edge tracking
  // ----------------------------------------------------------------
  assign sclk_rise = sclk & ~sclk_reg;
  assign sclk_fall = ~sclk & sclk_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_reg <= 1'b1;
      dir_reg <= 1'b0;
      since_rise_reg <= 4'hf;
      since_fall_reg <= 4'hf;
      nfall_reg <= 6'h00;
    end else begin
      sclk_reg <= sclk;
      since_rise_reg <= sclk_rise ? 4'h0 : since_rise_reg + {3'h0, since_rise_reg != 4'hf};
      since_fall_reg <= sclk_fall ? 4'h0 : since_fall_reg + {3'h0, since_fall_reg != 4'hf};
      nfall_reg <= cs_n ? 6'h00 : nfall_reg + {5'h00, sclk_fall};
      if (sclk_fall && !cs_n && nfall_reg == 6'h00) begin
        dir_reg <= din;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_idle_float: assert property (cs_n [*6] |-> !dout_oe)
    else $error("data output driven while deselected");
  chk_abort_float: assert property ($rose(cs_n) |-> ##[1:6] !dout_oe)
    else $error("data output not floated after select rise");
  chk_read_start: assert property ($rose(dout_oe) |-> sclk && nfall_reg == 6'h08 && since_rise_reg <= 4'h6)
    else $error("data output enabled at wrong point");
  chk_read_hold: assert property (dout_oe && !cs_n && nfall_reg < 6'h10 |=> dout_oe)
    else $error("read dropped before last bit");
  chk_dout_on_rise: assert property ($changed(dout) && dout_oe && $past(dout_oe) |-> since_rise_reg <= 4'h6)
    else $error("data output changed away from a clock rise");
  chk_end_float: assert property ($fell(dout_oe) && !cs_n |-> !sclk && since_fall_reg <= 4'h6)
    else $error("read end float not on final fall");
  chk_end_count: assert property ($fell(dout_oe) && !cs_n |-> nfall_reg inside {6'h10, 6'h18, 6'h20})
    else $error("read ended after a partial byte");
  chk_write_quiet: assert property (dir_reg && !cs_n |-> !dout_oe)
    else $error("data output driven during write");
endmodule : serial_register_access_port_sva

/* File: dv/serial_register_access_port_tb.sv */
// Purpose: self-checking bench for host and register port joined by the link
// Assumes: second port on its own link is driven directly for fault cases
// Notes: a small register file model answers the main port
`timescale 1ns/10ps
module serial_register_access_port_tb
  import access_pkg::*;
();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [ADDR_BITS-1:0] reg_addr;
  logic [ADDR_BITS-1:0] reg_addr_b;
  logic [1:0] reg_len;
  logic [DATA_BITS-1:0] rd_data;
  logic wr_strobe;
  logic wr_strobe_b;
  logic [7:0] wr_data;
  logic [7:0] wr_data_b;
  logic [1:0] wr_byte_idx;
  logic [1:0] wr_byte_idx_b;
  logic [DATA_BITS-1:0] regs [32];
  logic [1:0] lens [32];
  logic [31:0] q;
  int failures = 0;
  int n_checks = 0;
  int strobes_b = 0;

  always #12.5 clk = ~clk;

  serial_link_if i_serial_link_if ();
  serial_link_if i_serial_link_if_b ();

  serial_host i_serial_host (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(i_serial_link_if.host));
  register_port i_register_port (.clk(clk), .rst_n(rst_n), .link(i_serial_link_if.device), .reg_addr(reg_addr),
    .reg_len(reg_len), .rd_data(rd_data), .wr_strobe(wr_strobe), .wr_data(wr_data), .wr_byte_idx(wr_byte_idx));
  register_port i_register_port_b (.clk(clk), .rst_n(rst_n), .link(i_serial_link_if_b.device),
    .reg_addr(reg_addr_b), .reg_len(2'h1), .rd_data(24'h00_00a5), .wr_strobe(wr_strobe_b),
    .wr_data(wr_data_b), .wr_byte_idx(wr_byte_idx_b));
  serial_register_access_port_sva i_sva (.clk(clk), .rst_n(rst_n), .sclk(i_serial_link_if.sclk),
    .cs_n(i_serial_link_if.cs_n), .din(i_serial_link_if.din), .dout(i_serial_link_if.dout),
    .dout_oe(i_serial_link_if.dout_oe));

  // ----------------------------------------------------------------
  // register file model behind the main port
  // ----------------------------------------------------------------
  assign reg_len = lens[reg_addr];
  assign rd_data = regs[reg_addr];

  always @(posedge clk) begin
    if (wr_strobe === 1'b1) begin
      regs[reg_addr][8*wr_byte_idx +: 8] <= wr_data;
    end
    if (wr_strobe_b === 1'b1) begin
      strobes_b <= strobes_b + 1;
    end
  end

  // contents change once the read is under way; the copy must not follow
  always @(posedge i_serial_link_if.dout_oe) begin
    if (reg_addr === 5'h06) begin
      regs[6] <= 24'h0f_0f0f;
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic bus(input logic [1:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    // ends when avs_waitrequest goes low; no timeout here, only the watchdog catches a hang
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic run(input logic [7:0] cmd, input logic [1:0] len, input logic [23:0] txd);
    int n;
    n = 0;
    bus(TXD_IDX, 1'b1, {8'h00, txd});
    bus(CTRL_IDX, 1'b1, (32'h1 << CTRL_START_POS) | (32'(len) << CTRL_LEN_POS) | 32'(cmd));
    q = 32'h0000_0000;
    while (q[1] !== 1'b1 && n < 600) begin
      bus(STAT_IDX, 1'b0, 32'h0000_0000);
      n++;
    end
    if (q[1] !== 1'b1) failures++;
  endtask : run

  task automatic read_back(input string what, input logic [7:0] cmd, input logic [1:0] len, input logic [31:0] exp);
    run(cmd, len, 24'h00_0000);
    bus(RXD_IDX, 1'b0, 32'h0000_0000);
    check_val(what, exp, q);
  endtask : read_back

  // one bit per 200 ns: din set while sclk high, fall after 100 ns
  task automatic bang(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      i_serial_link_if_b.din <= v[i];
      repeat (4) @(posedge clk);
      i_serial_link_if_b.sclk <= 1'b0;
      repeat (4) @(posedge clk);
      i_serial_link_if_b.sclk <= 1'b1;
    end
  endtask : bang

  task automatic final_report();
    $display("summary: %0d checks, %0d mismatches", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #(25 * 30000);
    failures++;
    final_report();
  end

  initial begin
    i_serial_link_if_b.sclk = 1'b1;
    i_serial_link_if_b.cs_n = 1'b1;
    i_serial_link_if_b.din = 1'b0;
    for (int i = 0; i < 32; i++) begin
      regs[i] = 24'h00_0000;
      lens[i] = 2'h3;
    end
    regs[4] = 24'h77_6640;
    lens[4] = 2'h1;
    lens[7] = 2'h2;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus(STAT_IDX, 1'b0, 32'h0000_0000);
    check_val("status after reset", 32'h0000_0000, q & 32'h0000_0003);
    $display("test reset state finished");
    run(8'h86, 2'h3, 24'h12_3456);
    check_val("reg 6 written", 32'h0012_3456, {8'h00, regs[6]});
    run(8'h87, 2'h2, 24'h00_fabc);
    check_val("reg 7 written", 32'h0000_fabc, {8'h00, regs[7]});
    $display("test writes finished");
    read_back("read reg 4", 8'h04, 2'h1, 32'h0000_0040);
    read_back("read reg 6", 8'h06, 2'h3, 32'h0012_3456);
    read_back("read reg 7", 8'h07, 2'h2, 32'h0000_fabc);
    $display("test reads finished");
    i_serial_link_if_b.cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    bang(8'h86, 8);
    bang(8'h3c, 4);
    repeat (2) @(posedge clk);
    i_serial_link_if_b.cs_n <= 1'b1;
    i_serial_link_if_b.din <= ~i_serial_link_if_b.din;
    repeat (12) @(posedge clk);
    check_val("strobes after abort", 32'h0000_0000, 32'(strobes_b));
    i_serial_link_if_b.cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    bang(8'h86, 8);
    bang(8'h3c, 8);
    repeat (8) @(posedge clk);
    check_val("strobes after write", 32'h0000_0001, 32'(strobes_b));
    check_val("byte index and data", 32'h0000_003c, {22'h00_0000, wr_byte_idx_b, wr_data_b});
    check_val("address from command", 32'h0000_0006, {27'h000_0000, reg_addr_b});
    i_serial_link_if_b.cs_n <= 1'b1;
    repeat (10) @(posedge clk);
    i_serial_link_if_b.cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    bang(8'h05, 8);
    bang(8'h00, 1);
    repeat (6) @(posedge clk);
    check_val("output enable in read", 32'h0000_0001, {31'h0000_0000, i_serial_link_if_b.dout_oe});
    i_serial_link_if_b.cs_n <= 1'b1;
    repeat (6) @(posedge clk);
    check_val("output enable after abort", 32'h0000_0000, {31'h0000_0000, i_serial_link_if_b.dout_oe});
    $display("test aborts finished");
    final_report();
  end
endmodule : serial_register_access_port_tb
